//--- include/ads_defs.svh
// What this block does
// - External single cycle: sleep until SCK rises, CS low
// - Sample SDI on the first 8 rising SCK edges
// - New channel applies to next conversion only
// - SDO changes on falling edges; 24 bits
// - 24th external falling edge starts conversion, SDO high
// - CS low after frame keeps busy flag on SDO
// - External: CS rise mid-frame aborts, starts conversion
// - Abort loads channel only after 8th falling edge
// - Sample SCK level at end of power-on reset
// - CS low: busy flag shown; load result when it falls
// - SCK high at POR end or CS fall: internal
// - SCK low at those moments selects external clock
// - SDO released while CS high, driven while low
// - Status probe wakes device; CS high first resleeps
// - First internal rising edge after probe delay
// - Internal: after 24th rise convert, SCK/SDO high
// - Internal: CS rise mid-frame aborts, same 8-edge rule
// - Continuous: both low at end, half period, then frame
// - Continuous: 24th generated rise ends frame, converts
`ifndef ADS_DEFS_SVH
`define ADS_DEFS_SVH

// =====================================================
// Frame layout
`define ADS_FRAME_BITS 5'd24
`define ADS_CHAN_LOAD_EDGE 5'd8
`define ADS_CHAN_W 8
`define ADS_CHAN_DEFAULT 8'h00
`define ADS_EOC_READY 1'b0
`define ADS_EOC_BUSY 1'b1

// =====================================================
// Timing
`define ADS_CLK_MHZ 125
`define ADS_POR_TIME_US 4000
`define ADS_T_EOCTEST_NS 12000
`define ADS_EOSC_TENTHS 36
`define ADS_TIMER_W 20

`endif

//--- include/ads_pkg.sv
package ads_pkg;

   // =====================================================
   // Types
   typedef enum logic [2:0] {
      ADS_POR   = 3'h0,
      ADS_CONV  = 3'h1,
      ADS_SLEEP = 3'h3,
      ADS_PROBE = 3'h2,
      ADS_SHIFT = 3'h6,
      ADS_HALF  = 3'h7
   } ads_state_e;

   typedef enum logic {
      ADS_MODE_INT = 1'b0,
      ADS_MODE_EXT = 1'b1
   } ads_mode_e;

endpackage

//--- verilog/ads_sync.sv
`timescale 1ns/1ps
module ads_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // ads_sync

//--- verilog/ads_fifo.sv
`timescale 1ns/1ps
module ads_fifo #(
   parameter int W = 23,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr != rd_ptr;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // ads_fifo

//--- verilog/ads_serial.sv
`timescale 1ns/1ps
`include "ads_defs.svh"
module ads_serial #(
   parameter int RES_W = 23,
   parameter int FIFO_DEPTH = 16,
   parameter int INT_HALF = 10,
   parameter int EXT_OSC_KHZ = 307,
   parameter int POR_CYCLES = `ADS_POR_TIME_US * `ADS_CLK_MHZ
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic CS_N,
   input wire logic SDI,
   input wire logic SCK_IN,
   output logic SCK_OUT,
   output logic SCK_OE_N,
   output logic SCK_PULLUP,
   output logic SDO_OUT,
   output logic SDO_OE_N,
   input wire logic OSC_SELECT,
   input wire logic [RES_W-1:0] RESULT_DATA,
   input wire logic RESULT_VALID,
   output logic RESULT_READY,
   output logic CONV_START,
   output logic [`ADS_CHAN_W-1:0] CONV_CHANNEL,
   output ads_pkg::ads_mode_e SCK_MODE
);
   import ads_pkg::*;

   function automatic int ceil_div(input int n, input int d);
      ceil_div = (n + d - 1) / d;
   endfunction

   // Least times round up to whole clock cycles
   localparam int PROBE_INT = ceil_div(`ADS_T_EOCTEST_NS * `ADS_CLK_MHZ, 1000);
   localparam int PROBE_EXT = ceil_div(`ADS_EOSC_TENTHS * `ADS_CLK_MHZ * 1000,
                                       10 * EXT_OSC_KHZ);
   localparam logic [`ADS_TIMER_W-1:0] POR_LOAD = `ADS_TIMER_W'(POR_CYCLES - 1);
   // Probe delay includes the half period before the first rise
   localparam logic [`ADS_TIMER_W-1:0] PROBE_INT_LOAD = `ADS_TIMER_W'(PROBE_INT - 1 - INT_HALF);
   localparam logic [`ADS_TIMER_W-1:0] PROBE_EXT_LOAD = `ADS_TIMER_W'(PROBE_EXT - 1 - INT_HALF);
   localparam logic [`ADS_TIMER_W-1:0] HALF_LOAD = `ADS_TIMER_W'(INT_HALF - 1);
   localparam logic [7:0] HALF_TOP = 8'(INT_HALF - 1);
   localparam logic [4:0] LAST_EDGE = `ADS_FRAME_BITS - 5'd1;

   // =====================================================
   // Reset release
   logic [1:0] rst_pipe;
   logic rst_n;

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // =====================================================
   // Pin synchronisers and edge finders
   logic [3:0] pins_s;
   logic cs_s;
   logic sdi_s;
   logic sck_s;
   logic osc_s;
   logic cs_d;
   logic sck_d;

   ads_sync #(.W(4), .INIT(4'h8)) u_sync (
      .clk(CLOCK),
      .rst_n(rst_n),
      .d({CS_N, SDI, SCK_IN, OSC_SELECT}),
      .q(pins_s)
   );
   assign {cs_s, sdi_s, sck_s, osc_s} = pins_s;

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         cs_d <= 1'b1;
         sck_d <= 1'b0;
      end else begin
         cs_d <= cs_s;
         sck_d <= sck_s;
      end
   end

   logic cs_rise;
   logic cs_fall;
   logic ext_rise;
   logic ext_fall;

   assign cs_rise = cs_s & ~cs_d;
   assign cs_fall = ~cs_s & cs_d;
   assign ext_rise = sck_s & ~sck_d;
   assign ext_fall = ~sck_s & sck_d;

   // =====================================================
   // Result buffer: converter results wait here until a conversion ends
   logic res_valid;
   logic res_pop;
   logic [RES_W-1:0] res_data;
   ads_state_e state;
   ads_state_e next_state;

   assign res_pop = (state == ADS_CONV);

   ads_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLOCK),
      .rst_n(rst_n),
      .in_valid(RESULT_VALID),
      .in_ready(RESULT_READY),
      .in_data(RESULT_DATA),
      .out_valid(res_valid),
      .out_ready(res_pop),
      .out_data(res_data)
   );

   // =====================================================
   // Serial clock: external edges or generated ones
   ads_mode_e mode;
   logic ext_mode;
   logic int_sck;
   logic [7:0] half_cnt;
   logic half_tick;
   logic rise_ev;
   logic fall_ev;
   logic [`ADS_TIMER_W-1:0] timer;
   logic [4:0] rise_cnt;
   logic [4:0] fall_cnt;

   assign ext_mode = (mode == ADS_MODE_EXT);
   assign SCK_MODE = mode;
   assign half_tick = (state == ADS_SHIFT) & ~ext_mode & (half_cnt == HALF_TOP);
   assign rise_ev = ext_mode ? ext_rise : (half_tick & ~int_sck);
   assign fall_ev = ext_mode ? ext_fall : (half_tick & int_sck);

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         half_cnt <= 8'h00;
         int_sck <= 1'b0;
      end else if (state == ADS_SHIFT && !ext_mode) begin
         half_cnt <= half_tick ? 8'h00 : half_cnt + 8'h01;
         if (half_tick) begin
            int_sck <= ~int_sck;
         end
      end else begin
         half_cnt <= 8'h00;
         int_sck <= 1'b0;
      end
   end

   // =====================================================
   // Mode choice from the SCK level
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         mode <= ADS_MODE_INT;
      end else if ((state == ADS_POR && timer == '0) || cs_fall) begin
         mode <= sck_s ? ADS_MODE_INT : ADS_MODE_EXT;
      end
   end

   // =====================================================
   // Sequencer
   logic started;
   logic frame_done;
   logic start_conv;
   logic load_chan;
   logic first_rise;

   // Abort window opens at the 1st falling edge (external) or 1st rise
   assign started = ext_mode ? (fall_cnt != 5'd0) : (rise_cnt != 5'd0);
   assign frame_done = ext_mode ? (fall_ev && fall_cnt == LAST_EDGE)
                                : (fall_ev && rise_cnt == `ADS_FRAME_BITS);

   always_comb begin
      next_state = state;
      start_conv = 1'b0;
      load_chan = 1'b0;
      unique case (state)
         ADS_POR: begin
            if (timer == '0) begin
               next_state = ADS_CONV;
               start_conv = 1'b1;
            end
         end
         ADS_CONV: begin
            if (res_valid) begin
               // Tied-low CS while internal: no probe delay, half period only
               next_state = (!ext_mode && !cs_s) ? ADS_HALF : ADS_SLEEP;
            end
         end
         ADS_SLEEP: begin
            if (!cs_s && !cs_fall) begin
               if (ext_mode) begin
                  if (ext_rise) begin
                     next_state = ADS_SHIFT;
                  end
               end else begin
                  next_state = ADS_PROBE;
               end
            end
         end
         ADS_PROBE: begin
            if (cs_s) begin
               next_state = ADS_SLEEP;
            end else if (timer == '0) begin
               next_state = ADS_SHIFT;
            end
         end
         ADS_HALF: begin
            if (cs_s) begin
               next_state = ADS_SLEEP;
            end else if (timer == '0) begin
               next_state = ADS_SHIFT;
            end
         end
         ADS_SHIFT: begin
            if (cs_rise && started) begin
               next_state = ADS_CONV;
               start_conv = 1'b1;
               load_chan = (fall_cnt >= `ADS_CHAN_LOAD_EDGE);
            end else if (cs_rise) begin
               next_state = ADS_SLEEP;
            end else if (frame_done) begin
               next_state = ADS_CONV;
               start_conv = 1'b1;
               load_chan = 1'b1;
            end
         end
         default: begin
            next_state = ADS_POR;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state <= ADS_POR;
      end else begin
         state <= next_state;
      end
   end

   // =====================================================
   // Shared timer: power-on interval, probe delay, half period
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         timer <= POR_LOAD;
      end else if (next_state == ADS_PROBE && state != ADS_PROBE) begin
         timer <= osc_s ? PROBE_EXT_LOAD : PROBE_INT_LOAD;
      end else if (next_state == ADS_HALF && state != ADS_HALF) begin
         timer <= HALF_LOAD;
      end else if (timer != '0) begin
         timer <= timer - 1'b1;
      end
   end

   // =====================================================
   // Edge counters and channel word input
   logic [`ADS_CHAN_W-1:0] chan_shift;
   logic [`ADS_CHAN_W-1:0] chan;

   // The rise that wakes an external frame is itself the first data bit
   assign first_rise = (state == ADS_SLEEP) && (next_state == ADS_SHIFT);

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         rise_cnt <= 5'd0;
         fall_cnt <= 5'd0;
      end else if (state == ADS_SHIFT || first_rise) begin
         if (rise_ev) begin
            rise_cnt <= rise_cnt + 5'd1;
         end
         if (fall_ev && state == ADS_SHIFT) begin
            fall_cnt <= fall_cnt + 5'd1;
         end
      end else begin
         rise_cnt <= 5'd0;
         fall_cnt <= 5'd0;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         chan_shift <= `ADS_CHAN_DEFAULT;
      end else if ((state == ADS_SHIFT || first_rise) && rise_ev
                   && rise_cnt < `ADS_CHAN_LOAD_EDGE) begin
         chan_shift <= {chan_shift[`ADS_CHAN_W-2:0], sdi_s};
      end
   end

   // Channel only changes at a conversion start, never mid-conversion
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         chan <= `ADS_CHAN_DEFAULT;
         CONV_CHANNEL <= `ADS_CHAN_DEFAULT;
         CONV_START <= 1'b0;
      end else begin
         CONV_START <= start_conv;
         if (load_chan) begin
            chan <= chan_shift;
         end
         if (start_conv) begin
            CONV_CHANNEL <= load_chan ? chan_shift : chan;
         end
      end
   end

   // =====================================================
   // Result shift register and SDO
   logic [`ADS_FRAME_BITS-1:0] out_shift;

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         out_shift <= '0;
      end else if (state == ADS_CONV && res_valid) begin
         out_shift <= {`ADS_EOC_READY, res_data};
      end else if (state == ADS_SHIFT && fall_ev) begin
         out_shift <= {out_shift[`ADS_FRAME_BITS-2:0], 1'b0};
      end
   end

   // Ready (low) flag leads every frame, so the first rise sees it
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         SDO_OUT <= `ADS_EOC_BUSY;
      end else if (next_state == ADS_CONV || next_state == ADS_POR) begin
         SDO_OUT <= `ADS_EOC_BUSY;
      end else if (state != ADS_SHIFT) begin
         SDO_OUT <= `ADS_EOC_READY;
      end else if (fall_ev) begin
         SDO_OUT <= out_shift[`ADS_FRAME_BITS-2];
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         SDO_OE_N <= 1'b1;
      end else begin
         SDO_OE_N <= cs_s;
      end
   end

   // =====================================================
   // SCK drive in internal mode
   // Held high while converting so a CS fall keeps internal mode
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         SCK_OE_N <= 1'b1;
         SCK_OUT <= 1'b0;
      end else if (ext_mode || state == ADS_POR || next_state == ADS_POR
                   || next_state == ADS_SLEEP) begin
         SCK_OE_N <= 1'b1;
         SCK_OUT <= 1'b0;
      end else begin
         SCK_OE_N <= 1'b0;
         unique case (next_state)
            ADS_CONV: SCK_OUT <= 1'b1;
            ADS_SHIFT: SCK_OUT <= half_tick ? ~int_sck : int_sck;
            default: SCK_OUT <= 1'b0;
         endcase
      end
   end

   // Pull-up on while deselected and SCK not driven so a floating pin reads high at select;
   // off while selected and the pin sits low
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         SCK_PULLUP <= 1'b1;
      end else begin
         SCK_PULLUP <= (state == ADS_POR) | (SCK_OE_N & (sck_s | cs_s));
      end
   end
endmodule // ads_serial

//--- testbench/ads_serial_checker.sv
`timescale 1ns/1ps
`include "ads_defs.svh"
module ads_serial_checker (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic CS_N,
   input wire logic SCK_IN,
   input wire logic SCK_OUT,
   input wire logic SCK_OE_N,
   input wire logic SDO_OUT,
   input wire logic SDO_OE_N,
   input wire logic CONV_START,
   input wire logic [`ADS_CHAN_W-1:0] CONV_CHANNEL,
   input wire ads_pkg::ads_mode_e SCK_MODE
);
   import ads_pkg::*;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   // =====================================================
   // Link pins
   property p_sdo_release;
      CS_N [*4] |-> SDO_OE_N;
   endproperty
   a_sdo_release: assert property (p_sdo_release) else $error("SDO driven while idle");
   property p_sdo_drive;
      !CS_N [*5] |-> !SDO_OE_N;
   endproperty
   a_sdo_drive: assert property (p_sdo_drive) else $error("SDO not driven");
   property p_mode_int;
      $fell(CS_N) && SCK_IN |-> ##[1:5] SCK_MODE == ADS_MODE_INT;
   endproperty
   a_mode_int: assert property (p_mode_int) else $error("internal clock not chosen");
   property p_mode_ext;
      $fell(CS_N) && !SCK_IN |-> ##[1:5] SCK_MODE == ADS_MODE_EXT;
   endproperty
   a_mode_ext: assert property (p_mode_ext) else $error("external clock not chosen");
   // Clock must stay released while the host owns it
   property p_ext_no_drive;
      SCK_MODE == ADS_MODE_EXT && $past(SCK_MODE) == ADS_MODE_EXT |-> SCK_OE_N;
   endproperty
   a_ext_no_drive: assert property (p_ext_no_drive) else $error("clock driven in ext mode");
   // =====================================================
   // Conversion start
   property p_start_pulse;
      CONV_START |=> !CONV_START;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
   property p_busy_flag;
      CONV_START && !SDO_OE_N |-> ##[0:3] SDO_OUT;
   endproperty
   a_busy_flag: assert property (p_busy_flag) else $error("busy flag missing");
   property p_int_sck_high;
      CONV_START && SCK_MODE == ADS_MODE_INT |-> ##[0:3] (SCK_OUT && !SCK_OE_N);
   endproperty
   a_int_sck_high: assert property (p_int_sck_high) else $error("clock not held high");
   property p_chan_hold;
      !CONV_START |-> $stable(CONV_CHANNEL);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid conversion");
   // Deselected and idle: nothing may start
   property p_sleep;
      (SCK_MODE == ADS_MODE_EXT && CS_N) [*8] |-> !CONV_START;
   endproperty
   a_sleep: assert property (p_sleep) else $error("start while asleep");
endmodule // ads_serial_checker

bind ads_serial ads_serial_checker ads_serial_checker_i (.CLOCK(CLOCK), .RSTN(RSTN),
   .CS_N(CS_N), .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N),
   .SDO_OUT(SDO_OUT), .SDO_OE_N(SDO_OE_N), .CONV_START(CONV_START),
   .CONV_CHANNEL(CONV_CHANNEL), .SCK_MODE(SCK_MODE));

//--- testbench/ads_host_model.sv
`timescale 1ns/1ps
module ads_host_model (
   input wire logic clk,
   input wire logic sdo,
   input wire logic sck_pin,
   output logic cs_n,
   output logic sck,
   output logic sck_en,
   output logic sdi
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sck_en = 1'b1;
      sdi = 1'b0;
   end
   // =====================================================
   // External clock frame, n pulses, abort when n < 24
   task ext_frame(input int n, input logic [7:0] chan, output logic [23:0] got);
      got = '0;
      sck_en = 1'b1;
      sck = 1'b0;
      #3 cs_n = 1'b0;
      #400;
      for (int i = 0; i < n; i++) begin
         sdi = (i < 8) ? chan[7-i] : ~sdi;
         #40 got = {got[22:0], sdo};
         sck = 1'b1;
         #40 sck = 1'b0;
      end
      // Full frames leave select low so the busy flag can be watched
      if (n < 24) #120 cs_n = 1'b1;
   endtask
   task cs_up();
      #3 cs_n = 1'b1;
   endtask
   // =====================================================
   // Internal clock frame: release clock, follow device edges
   task int_frame(input logic [7:0] chan, output logic [23:0] got, output int first);
      int t;
      int r;
      logic p;
      got = '0;
      t = 0;
      r = 0;
      first = 0;
      sck_en = 1'b0;
      sdi = chan[7];
      #200 @(negedge clk);
      cs_n = 1'b0;
      p = sck_pin;
      while (r < 24 && t < 4000) begin
         @(negedge clk);
         t++;
         if (sck_pin && !p) begin
            if (r == 0) first = t;
            got = {got[22:0], sdo};
            r++;
         end
         if (!sck_pin && p) sdi = (r < 8) ? chan[7-r] : ~sdi;
         p = sck_pin;
      end
   endtask
endmodule // ads_host_model

//--- testbench/ads_serial_tb_top.sv
`timescale 1ns/1ps
`include "ads_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
   $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module ads_serial_tb_top;
   import ads_pkg::*;
   logic clock = 1'b0;
   logic rstn, result_valid, result_ready, flick;
   logic [22:0] result_data;
   logic sck_out, sck_oe_n, sck_pullup, sdo_out, sdo_oe_n, conv_start;
   logic cs_n, host_sck, host_en, sdi;
   logic [7:0] conv_channel, last_chan, cur_chan;
   ads_mode_e sck_mode;
   wire logic sck_pin;
   wire logic sdo_pin;
   int failures = 0;
   int check_count = 0;
   int starts = 0;
   logic [22:0] q[$];
   always #4 clock = ~clock;
   // Undriven pins must not look like stable data
   always @(posedge clock) flick <= ~flick;
   assign sck_pin = !sck_oe_n ? sck_out : host_en ? host_sck : sck_pullup ? 1'b1 : flick;
   assign sdo_pin = sdo_oe_n ? flick : sdo_out;
   always @(posedge clock) if (conv_start === 1'b1) begin
      starts++;
      last_chan = conv_channel;
   end
   ads_serial #(.POR_CYCLES(50)) ads_serial_i (.CLOCK(clock), .RSTN(rstn), .CS_N(cs_n),
      .SDI(sdi), .SCK_IN(sck_pin), .SCK_OUT(sck_out), .SCK_OE_N(sck_oe_n),
      .SCK_PULLUP(sck_pullup), .SDO_OUT(sdo_out), .SDO_OE_N(sdo_oe_n), .OSC_SELECT(1'b0),
      .RESULT_DATA(result_data), .RESULT_VALID(result_valid), .RESULT_READY(result_ready),
      .CONV_START(conv_start), .CONV_CHANNEL(conv_channel), .SCK_MODE(sck_mode));
   ads_host_model ads_host_model_i (.clk(clock), .sdo(sdo_pin), .sck_pin(sck_pin),
      .cs_n(cs_n), .sck(host_sck), .sck_en(host_en), .sdi(sdi));
   // =====================================================
   // Helpers
   task complete_run();
      $display("Counts: failures %0d, checks %0d", failures, check_count);
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task push(input logic [22:0] w);
      @(negedge clock);
      result_valid = 1'b1;
      result_data = w;
      @(negedge clock);
      result_valid = 1'b0;
      result_data = ~w;
   endtask
   initial begin
      #300000;
      failures++;
      complete_run();
   end
   // =====================================================
   // Main sequence
   initial begin
      int n;
      int s0;
      int first;
      int ns[6];
      logic [22:0] w;
      logic [23:0] got;
      logic [7:0] ch;
      ns = '{24, 0, 7, 8, 1, 23};
      rstn = 1'b0;
      result_valid = 1'b0;
      result_data = '0;
      flick = 1'b0;
      void'($urandom(32'he939));
      repeat (2) @(posedge clock);
      @(negedge clock) rstn = 1'b1;
      for (int i = 0; i < 200 && starts == 0; i++) @(negedge clock);
      `CHK(starts, 1)
      `CHK(sck_mode, ADS_MODE_EXT)
      cur_chan = 8'h00;
      for (int i = 0; i < 17; i++) begin
         w = 23'($urandom);
         q.push_back(w);
         push(w);
         if (i == 0) repeat (8) @(negedge clock);
      end
      `CHK(result_ready, 1'b0)
      // Drain: each frame with pulses frees one word, host paces the stall
      for (int k = 0; k < 18; k++) begin
         n = (k < 6) ? ns[k] : 1 + $urandom_range(23);
         ch = 8'($urandom);
         s0 = starts;
         ads_host_model_i.ext_frame(n, ch, got);
         if (n > 0) begin
            `CHK(got, {1'b0, q[0]} >> (24 - n))
            q.pop_front();
         end
         if (n == 24) begin
            repeat (20) @(negedge clock);
            `CHK({sdo_oe_n, sdo_pin}, {1'b0, q.size() == 0})
            ads_host_model_i.cs_up();
         end
         repeat (12) @(negedge clock);
         if (n >= 8) cur_chan = ch;
         `CHK(starts, s0 + (n > 0))
         `CHK(last_chan, cur_chan)
         #200;
      end
      w = 23'($urandom);
      push(w);
      repeat (4) @(negedge clock);
      `CHK(sck_pullup, 1'b1)
      ch = 8'($urandom);
      s0 = starts;
      ads_host_model_i.int_frame(ch, got, first);
      `CHK(got, {1'b0, w})
      `CHK(first >= 1500 && first <= 1512, 1'b1)
      repeat (30) @(negedge clock);
      `CHK(sck_mode, ADS_MODE_INT)
      `CHK({sck_out, sck_oe_n, sdo_out}, 3'b101)
      `CHK(starts, s0 + 1)
      `CHK(last_chan, ch)
      ads_host_model_i.cs_up();
      complete_run();
   end
endmodule // ads_serial_tb_top
